/* File: logic/usfg_defs.svh */
// register offsets, field positions, reset values and levels of the
// status, flow, level and pin register group of one serial channel.
// assumes the includer compiles it once per unit; guard keeps it safe.
`ifndef USFG_DEFS_SVH
`define USFG_DEFS_SVH

// ******************************************************
// register offsets
// ******************************************************
`define USFG_OFS_LINE_STATUS  4'h5
`define USFG_OFS_MODEM_STAT   4'h6
`define USFG_OFS_THRESHOLDS   4'h6
`define USFG_OFS_SCRATCH      4'h7
`define USFG_OFS_TRIGGERS     4'h7
`define USFG_OFS_TX_FREE      4'h8
`define USFG_OFS_RX_FILL      4'h9
`define USFG_OFS_PIN_DIR      4'hA
`define USFG_OFS_PIN_LEVEL    4'hB
`define USFG_OFS_PIN_IRQ_EN   4'hC
`define USFG_OFS_PIN_FUNC     4'hE

// ******************************************************
// fields, reset values and levels
// ******************************************************
`define USFG_FUNC_LATCH       0
`define USFG_FUNC_MODEM_A     1
`define USFG_FUNC_MODEM_B     2
`define USFG_FUNC_SW_RESET    3
`define USFG_SCRATCH_RESET    8'hFF
`define USFG_FIFO_DEPTH       64
`define USFG_FIFO_WIDTH       11
`define USFG_FIFO_FULL        7'h40
`define USFG_LVL_CODE0        7'h08
`define USFG_LVL_CODE1        7'h10
`define USFG_LVL_CODE2        7'h38
`define USFG_LVL_CODE3        7'h3C

`endif

/* File: logic/usfg_pkg.sv */
// types shared by the status, flow, level and pin register group.
// assumes nothing of its surroundings.
package usfg_pkg;

  // receive flow control: running or halted
  typedef enum logic {USFG_RUN, USFG_HALT} usfg_flow_t;

  // whole state of the register group
  typedef struct packed {
    logic       ovr;
    logic       brk_seen;
    logic [6:0] errcnt;
    logic [3:0] delta;
    logic [3:0] mprev;
    logic [7:0] scratch;
    logic [7:0] thresh;
    logic [7:0] trig;
    logic [7:0] dir;
    logic [7:0] lvl;
    logic [7:0] ien;
    logic [2:0] func;
    logic       srst;
    logic [7:0] gp_ref;
    logic [7:0] gp_pend;
    logic [7:0] gp_latch;
    logic [7:0] rdata;
    logic       rvalid;
    usfg_flow_t flow;
    logic       xoff;
    logic       xon;
  } usfg_state_t;

endpackage

/* File: logic/usfg_regs.sv */
// status, flow threshold, fifo level and pin register group of one
// serial channel, with its receive fifo. assumes the serial engines,
// modem control and host port logic sit outside and are synchronous.
//
// Operation
// - receive-ready flag is set while any character waits in the fifo
// - character arriving on full fifo sets overrun, fifo left untouched
// - parity and framing tags follow the character at the read position
// - break tag flagged; one break character per break run enters the fifo
// - holding-empty flag set when no transmit byte is held
// - transmitter-empty set only when holding and shift register empty
// - fifo error flag stands while any stored byte carries a tag
// - change flags for cts, dsr, cd set on change; modem interrupt
// - ring change flag sets only at the end of ringing
// - with auto cts, high cts input stops transmitter after character
// - upper modem bits are inverted pins, or control bits in loopback
// - scratch register is eight bits and resets to all ones
// - halt level is low nibble times four; at or above it, halt
// - resume level is high nibble times four; at or below, resume
// - nonzero low nibble times four sets the transmit trigger
// - nonzero high nibble sets receive trigger; timeout independent
// - level registers report free transmit and stored receive counts
// - direction bit picks input or output; level reads pins, drives
// - pin change interrupts when enabled; upper enables off as modem
// - writing one to the reset bit resets, then bit clears itself
// - modem select bits give pin groups to ri, cd, dtr, dsr
// - threshold and trigger registers replace status and scratch
`timescale 1ns/10ps
`default_nettype none
`include "usfg_defs.svh"

// ******************************************************
// receive fifo
// ******************************************************
module usfg_fifo #(
  parameter  int W     = 11,
  parameter  int DEPTH = 64,
  localparam int AW    = $clog2(DEPTH)
) (
  input  wire logic          clk,       // device clock
  input  wire logic          rst,       // sync reset, high
  input  wire logic          in_valid,  // write offered
  output logic               in_ready,  // room left
  input  wire logic [W-1:0]  in_data,   // word written
  output logic               out_valid, // word waiting
  input  wire logic          out_ready, // reader takes word
  output logic [W-1:0]       out_data,  // head word
  output logic [AW:0]        count      // stored words
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } usfg_fifo_st_t;

  usfg_fifo_st_t s;
  usfg_fifo_st_t n;
  logic          push;
  logic          pop;

  // handshakes from stored count; depth is a power of two
  assign in_ready  = (s.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s.cnt != '0);
  assign out_data  = s.mem[s.rp];
  assign count     = s.cnt;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // next state of pointers and storage
  always_comb begin
    n = s;
    if (push) begin
      n.mem[s.wp] = in_data;
      n.wp        = s.wp + 1'b1;
    end
    if (pop) begin
      n.rp = s.rp + 1'b1;
    end
    n.cnt = s.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    if (rst) begin
      n = '0;
    end
  end

  // register the state
  always_ff @(posedge clk) begin
    s <= n;
  end
endmodule

// ******************************************************
// register group
// ******************************************************
module usfg_regs (
  input  wire logic       clk,            // 40 MHz device clock
  input  wire logic       reset,          // sync reset, high
  input  wire logic [3:0] reg_addr,       // register offset
  input  wire logic       reg_wr,         // write strobe
  input  wire logic       reg_rd,         // read strobe
  input  wire logic [7:0] reg_wdata,      // write data
  output logic [7:0]      reg_rdata,      // read data
  output logic            reg_rvalid,     // read data valid
  input  wire logic       cfg_enh_en,     // enhanced functions on
  input  wire logic [4:0] cfg_mcr,        // modem control bits 4..0
  input  wire logic [1:0] cfg_tx_code,    // fifo control tx level
  input  wire logic [1:0] cfg_rx_code,    // fifo control rx level
  input  wire logic       cfg_ms_int_en,  // modem int enable
  input  wire logic       cfg_auto_cts,   // auto cts on
  input  wire logic       cfg_auto_rts,   // auto rts on
  input  wire logic       cfg_sw_flow,    // auto xon/xoff on
  input  wire logic       rx_in_valid,    // char completed
  output logic            rx_in_ready,    // fifo has room
  input  wire logic [7:0] rx_in_data,     // char value
  input  wire logic       rx_in_par_err,  // bad parity
  input  wire logic       rx_in_frm_err,  // bad stop bit
  input  wire logic       rx_in_break,    // break char
  output logic            rx_out_valid,   // char waiting
  input  wire logic       rx_out_ready,   // holding reg read
  output logic [7:0]      rx_out_data,    // head char
  input  wire logic [6:0] tx_hold_count,  // tx bytes held
  input  wire logic       tx_shift_busy,  // tx shifter busy
  input  wire logic       rx_line_idle,   // rx idle timeout
  input  wire logic       cts_n,          // clear to send
  input  wire logic       dsr_n,          // data set ready
  input  wire logic       ri_n,           // ring indicator
  input  wire logic       cd_n,           // carrier detect
  input  wire logic [7:0] gpio_in,        // pin levels
  output logic [7:0]      gpio_out,       // pin drive values
  output logic [7:0]      gpio_oe,        // pin drive enables
  input  wire logic       chb_dtr_n,      // other channel dtr
  output logic [2:0]      chb_modem_n,    // other ch ri,cd,dsr
  output logic            rts_n,          // request to send
  output logic            tx_stop,        // hold transmitter
  output logic            xoff_req,       // send xoff, pulse
  output logic            xon_req,        // send xon, pulse
  output logic            tx_ready_int,   // tx space at trigger
  output logic            rx_data_int,    // rx fill at trigger
  output logic            rx_timeout_int, // rx timeout
  output logic            modem_int,      // modem status int
  output logic            gpio_int,       // pin change int
  output logic            soft_reset      // software reset pulse
);
  import usfg_pkg::*;

  usfg_state_t s;
  usfg_state_t n;
  logic        rst;
  logic        alt_map;
  logic        mdm_a;
  logic        mdm_b;
  logic        latch;
  logic [7:0]  line_status;
  logic [3:0]  mstat;
  logic [3:0]  mchg;
  logic [7:0]  modem_input_status;
  logic [6:0]  fill;
  logic [6:0]  free;
  logic [6:0]  halt_lvl;
  logic [6:0]  res_lvl;
  logic [6:0]  tx_trig;
  logic [6:0]  rx_trig;
  logic        f_ready;
  logic        f_valid;
  logic [10:0] f_head;
  logic        skip_brk;
  logic        push;
  logic        pop;
  logic        overrun;
  logic        push_tag;
  logic        pop_tag;
  logic [7:0]  gp_diff;
  logic [7:0]  gp_irq;
  logic [7:0]  gp_read;
  logic [7:0]  ien_eff;

  // level codes of the fifo control register
  function automatic logic [6:0] code_lvl(input logic [1:0] c);
    case (c)
      2'b00:   code_lvl = `USFG_LVL_CODE0;
      2'b01:   code_lvl = `USFG_LVL_CODE1;
      2'b10:   code_lvl = `USFG_LVL_CODE2;
      default: code_lvl = `USFG_LVL_CODE3;
    endcase
  endfunction

  // software reset acts one cycle after the write, as a sync reset
  assign rst     = reset | s.srst;
  assign alt_map = cfg_enh_en & cfg_mcr[2];
  assign mdm_a   = s.func[`USFG_FUNC_MODEM_A];
  assign mdm_b   = s.func[`USFG_FUNC_MODEM_B];
  assign latch   = s.func[`USFG_FUNC_LATCH];

  // ******************************************************
  // receive fifo and its tags
  // ******************************************************
  // one break char
  assign skip_brk = rx_in_break & s.brk_seen;
  assign push     = rx_in_valid & f_ready & ~skip_brk;
  assign overrun  = rx_in_valid & ~f_ready;
  assign pop      = f_valid & rx_out_ready;
  assign push_tag = push & (rx_in_par_err | rx_in_frm_err | rx_in_break);
  assign pop_tag  = pop & (|f_head[10:8]);

  usfg_fifo #(
    .W     (`USFG_FIFO_WIDTH),
    .DEPTH (`USFG_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (rx_in_valid & ~skip_brk),
    .in_ready  (f_ready),
    .in_data   ({rx_in_break, rx_in_frm_err, rx_in_par_err, rx_in_data}),
    .out_valid (f_valid),
    .out_ready (rx_out_ready),
    .out_data  (f_head),
    .count     (fill)
  );

  // engine may stall on ready; a char offered while full is lost
  assign rx_in_ready  = f_ready;
  assign rx_out_valid = f_valid;
  assign rx_out_data  = f_head[7:0];

  // ******************************************************
  // status words
  // ******************************************************
  // free space count
  assign free = `USFG_FIFO_FULL - tx_hold_count;
  // line status bits; tags only for a real head
  assign line_status = {s.errcnt != 7'h00,
                (tx_hold_count == 7'h00) & ~tx_shift_busy,
                tx_hold_count == 7'h00,
                f_head[10:8] & {3{f_valid}},
                s.ovr,
                f_valid};

  // loopback or inverted pins, order cd ri dsr cts
  always_comb begin
    if (cfg_mcr[4]) begin
      mstat = {cfg_mcr[3], cfg_mcr[2], cfg_mcr[0], cfg_mcr[1]};
    end else if (mdm_a) begin
      mstat = ~{gpio_in[6], gpio_in[7], gpio_in[4], cts_n};
    end else begin
      mstat = ~{cd_n, ri_n, dsr_n, cts_n};
    end
  end

  // change detect; ring only when the ring input goes high
  assign mchg = {mstat[3] ^ s.mprev[3],
                 s.mprev[2] & ~mstat[2],
                 mstat[1] ^ s.mprev[1],
                 mstat[0] ^ s.mprev[0]};
  assign modem_input_status  = {mstat, s.delta};

  // ******************************************************
  // levels, triggers and interrupt requests
  // ******************************************************
  // levels are nibble times four
  assign halt_lvl = {1'b0, s.thresh[3:0], 2'b00};
  assign res_lvl  = {1'b0, s.thresh[7:4], 2'b00};
  // zero nibble falls back to fifo control code
  assign tx_trig  = (s.trig[3:0] != 4'h0) ? {1'b0, s.trig[3:0], 2'b00}
                                          : code_lvl(cfg_tx_code);
  assign rx_trig  = (s.trig[7:4] != 4'h0) ? {1'b0, s.trig[7:4], 2'b00}
                                          : code_lvl(cfg_rx_code);
  assign tx_ready_int   = free >= tx_trig;
  assign rx_data_int    = fill >= rx_trig;
  assign rx_timeout_int = f_valid & rx_line_idle;
  assign modem_int      = cfg_ms_int_en & (|s.delta);
  // transmitter pacing; engine finishes the char in progress
  assign tx_stop        = cfg_auto_cts & cts_n;
  assign rts_n          = cfg_auto_rts ? (s.flow == USFG_HALT)
                                       : ~cfg_mcr[1];
  assign xoff_req       = s.xoff;
  assign xon_req        = s.xon;

  // ******************************************************
  // general purpose pins
  // ******************************************************
  // change since last read, inputs only; upper masked as modem
  assign gp_diff = (gpio_in ^ s.gp_ref) & ~s.dir;
  assign gp_irq  = latch ? s.gp_pend : gp_diff;
  assign ien_eff = s.ien & ~{{4{mdm_a}}, 4'h0};
  assign gpio_int = |(gp_irq & ien_eff);
  // latched bits keep the level that raised them
  assign gp_read = latch ? ((s.gp_pend & s.gp_latch) | (~s.gp_pend & gpio_in))
                         : gpio_in;

  // drive; dtr pins take the modem value when selected
  always_comb begin
    gpio_out = s.lvl;
    if (mdm_a) begin
      gpio_out[5] = ~cfg_mcr[0];
    end
    if (mdm_b) begin
      gpio_out[1] = chb_dtr_n;
    end
  end
  assign gpio_oe     = s.dir;
  assign chb_modem_n = mdm_b ? {gpio_in[3], gpio_in[2], gpio_in[0]} : 3'b111;
  assign reg_rdata   = s.rdata;
  assign reg_rvalid  = s.rvalid;
  assign soft_reset  = s.srst;

  // ******************************************************
  // next state
  // ******************************************************
  always_comb begin
    n        = s;
    n.rvalid = reg_rd;
    n.xoff   = 1'b0;
    n.xon    = 1'b0;
    n.srst   = 1'b0;
    n.mprev  = mstat;

    // break run ends with the first normal char
    if (push) begin
      n.brk_seen = rx_in_break;
    end
    n.errcnt = s.errcnt + {6'h00, push_tag} - {6'h00, pop_tag};

    case (s.flow)
      USFG_RUN: begin
        if (fill >= halt_lvl) begin
          n.flow = USFG_HALT;
          n.xoff = cfg_sw_flow;
        end
      end
      default: begin
        if (fill <= res_lvl) begin
          n.flow = USFG_RUN;
          n.xon  = cfg_sw_flow;
        end
      end
    endcase

    // latch mode pending bits and captured level
    n.gp_pend  = s.gp_pend | gp_diff;
    n.gp_latch = (s.gp_latch & s.gp_pend) | (gpio_in & ~s.gp_pend);

    // register reads and their side effects
    if (reg_rd) begin
      if (reg_addr == `USFG_OFS_LINE_STATUS) begin
        n.rdata = line_status;
        n.ovr   = 1'b0;
      end else if (alt_map && reg_addr == `USFG_OFS_THRESHOLDS) begin
        n.rdata = s.thresh;
      end else if (alt_map && reg_addr == `USFG_OFS_TRIGGERS) begin
        n.rdata = s.trig;
      end else if (reg_addr == `USFG_OFS_MODEM_STAT) begin
        n.rdata = modem_input_status;
        n.delta = 4'h0;
      end else if (reg_addr == `USFG_OFS_SCRATCH) begin
        n.rdata = s.scratch;
      end else if (reg_addr == `USFG_OFS_TX_FREE) begin
        n.rdata = {1'b0, free};
      end else if (reg_addr == `USFG_OFS_RX_FILL) begin
        n.rdata = {1'b0, fill};
      end else if (reg_addr == `USFG_OFS_PIN_DIR) begin
        n.rdata = s.dir;
      end else if (reg_addr == `USFG_OFS_PIN_LEVEL) begin
        n.rdata   = gp_read;
        n.gp_ref  = gpio_in;
        n.gp_pend = 8'h00;
      end else if (reg_addr == `USFG_OFS_PIN_IRQ_EN) begin
        n.rdata = s.ien;
      end else if (reg_addr == `USFG_OFS_PIN_FUNC) begin
        n.rdata = {5'h00, s.func};
      end else begin
        n.rdata = 8'h00;
      end
    end

    // register writes; read-only and unmapped offsets are ignored
    if (reg_wr) begin
      if (alt_map && reg_addr == `USFG_OFS_THRESHOLDS) begin
        n.thresh = reg_wdata;
      end else if (alt_map && reg_addr == `USFG_OFS_TRIGGERS) begin
        n.trig = reg_wdata;
      end else if (reg_addr == `USFG_OFS_SCRATCH) begin
        n.scratch = reg_wdata;
      end else if (reg_addr == `USFG_OFS_PIN_DIR) begin
        n.dir = reg_wdata;
      end else if (reg_addr == `USFG_OFS_PIN_LEVEL) begin
        n.lvl = reg_wdata;
      end else if (reg_addr == `USFG_OFS_PIN_IRQ_EN) begin
        n.ien = reg_wdata;
      end else if (reg_addr == `USFG_OFS_PIN_FUNC) begin
        n.func = reg_wdata[2:0];
        n.srst = reg_wdata[`USFG_FUNC_SW_RESET];
      end
    end

    // events win over a clearing read in the same cycle
    n.ovr   = n.ovr | overrun;
    n.delta = n.delta | mchg;

    // reset values; pin reference taken from the live pins
    if (rst) begin
      n         = '0;
      n.scratch = `USFG_SCRATCH_RESET;
      n.flow    = USFG_RUN;
      n.gp_ref  = gpio_in;
      n.mprev   = mstat;
    end
  end

  // register the state
  always_ff @(posedge clk) begin
    s <= n;
  end

  // ******************************************************
  // checks
  // ******************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence sw_reset_write;
    reg_wr && reg_addr == `USFG_OFS_PIN_FUNC && reg_wdata[3];
  endsequence

  rx_ready_push_a: assert property (push |=> line_status[0])
    else $error("ready flag missing after push");
  overrun_set_a: assert property (overrun |=> s.ovr)
    else $error("overrun not flagged");
  overrun_fill_a: assert property (overrun && !pop |=> fill == $past(fill))
    else $error("fifo changed on overrun");
  fifo_err_a: assert property (push_tag |=> line_status[7] && s.errcnt != 7'h00)
    else $error("fifo error flag missing");
  ring_edge_a: assert property (!cfg_mcr[4] && !mdm_a && $rose(ri_n)
                                |=> s.delta[2])
    else $error("ring change not flagged");
  halt_level_a: assert property (s.flow == USFG_RUN && fill >= halt_lvl
                                 |=> s.flow == USFG_HALT)
    else $error("flow did not halt");
  resume_level_a: assert property (s.flow == USFG_HALT && fill <= res_lvl
                                   |=> s.flow == USFG_RUN)
    else $error("flow did not resume");
  rx_fill_read_a: assert property (reg_rd && reg_addr == `USFG_OFS_RX_FILL
                                   |=> reg_rvalid &&
                                   reg_rdata == {1'b0, $past(fill)})
    else $error("fill count read wrong");
  sw_reset_a: assert property (@(posedge clk) disable iff (reset)
                               sw_reset_write |=> soft_reset ##1
                               !soft_reset)
    else $error("software reset pulse wrong");
endmodule
`default_nettype wire

/* File: testbench/usfg_rx_reader.sv */
// far-side model: the reader that pops the receive fifo.
// assumes one clock domain with a synchronous, active high reset.
`timescale 1ns/10ps
`default_nettype none
module usfg_rx_reader (
  input  wire logic clk,   // device clock
  input  wire logic reset, // sync reset, high
  input  wire logic en,    // reading allowed
  output logic      ready  // pop strobe
);
  // pops on alternate cycles only, so the fifo sees a stalling reader
  always_ff @(posedge clk) begin
    ready <= !reset && en && !ready;
  end
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
// self-checking bench for the status, flow, level and pin registers.
// assumes the register offsets of the defs header and a 40 MHz clock.
`timescale 1ns/10ps
`default_nettype none
`include "usfg_defs.svh"
module tb;
  typedef struct {logic wr; logic [3:0] a; logic [7:0] d;} usfg_row_t;
  logic       clk, reset, reg_wr, reg_rd, reg_rvalid, rd_en;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rx_in_data, gpio_in;
  logic [4:0] cfg_mcr;
  logic [6:0] tx_hold_count;
  logic       cfg_enh_en, cfg_ms_int_en, cfg_auto_cts, cfg_auto_rts;
  logic       rx_in_valid, rx_in_ready, rx_in_par_err, rx_in_frm_err;
  logic       rx_in_break, rx_out_valid, rx_out_ready, tx_shift_busy;
  logic       cts_n, dsr_n, ri_n, cd_n, rts_n, tx_stop, modem_int, gpio_int;
  logic [7:0] rx_out_data, gpio_out, gpio_oe;
  logic [2:0] chb_modem_n;
  logic       tx_ready_int, rx_data_int;
  int         error_cnt, total_checks, n;
  // ******************************************************
  // plain register cases: write rows carry data, read rows expectation
  // ******************************************************
  usfg_row_t rows [16] = '{
    '{0, 4'h7, 8'hFF}, '{0, 4'h9, 8'h00}, '{0, 4'h8, 8'h40},
    '{0, 4'h5, 8'h60}, '{0, 4'h6, 8'h00}, '{0, 4'hB, 8'hA5},
    '{1, 4'h7, 8'h5A}, '{0, 4'h7, 8'h5A}, '{1, 4'hA, 8'h0F},
    '{0, 4'hA, 8'h0F}, '{1, 4'hD, 8'h33}, '{0, 4'hD, 8'h00},
    '{1, 4'hE, 8'h08}, '{0, 4'hD, 8'h00}, '{0, 4'h7, 8'hFF},
    '{0, 4'hA, 8'h00}};
  usfg_regs dut_u (.clk, .reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .reg_rvalid, .cfg_enh_en, .cfg_mcr, .cfg_tx_code(2'b00),
    .cfg_rx_code(2'b00), .cfg_ms_int_en, .cfg_auto_cts, .cfg_auto_rts,
    .cfg_sw_flow(1'b0), .rx_in_valid, .rx_in_ready, .rx_in_data,
    .rx_in_par_err, .rx_in_frm_err, .rx_in_break, .rx_out_valid,
    .rx_out_ready, .rx_out_data, .tx_hold_count, .tx_shift_busy,
    .rx_line_idle(1'b0), .cts_n, .dsr_n, .ri_n, .cd_n, .gpio_in,
    .gpio_out, .gpio_oe, .chb_dtr_n(1'b1), .chb_modem_n, .rts_n,
    .tx_stop, .xoff_req(), .xon_req(), .tx_ready_int, .rx_data_int,
    .rx_timeout_int(), .modem_int, .gpio_int, .soft_reset());
  usfg_rx_reader rd_u (.clk, .reset, .en(rd_en), .ready(rx_out_ready));
  // ******************************************************
  // shared tasks
  // ******************************************************
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, s, e);
    end
  endtask
  // every bus task waits an edge first so no strobe is set twice at once
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk); #2 reg_addr = a; reg_wdata = d; reg_wr = 1;
    @(posedge clk); #2 reg_wr = 0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk); #2 reg_addr = a; reg_rd = 1;
    @(posedge clk); #2 reg_rd = 0;
    chk(reg_rvalid, 1);
    chk(reg_rdata, e);
  endtask
  task automatic push(input logic [7:0] d, input logic [2:0] t);
    rx_in_data = d;
    {rx_in_par_err, rx_in_frm_err, rx_in_break} = t;
    rx_in_valid = 1;
    @(posedge clk); #2 rx_in_valid = 0;
    @(posedge clk); #2;
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    #(25 * 5000);
    error_cnt++;
    close_out();
  end
  // ******************************************************
  // main sequence
  // ******************************************************
  initial begin
    {reg_wr, reg_rd, rx_in_valid, rx_in_par_err, rx_in_frm_err} = '0;
    {rx_in_break, rd_en, tx_shift_busy, cfg_auto_cts, cfg_auto_rts} = '0;
    {cts_n, dsr_n, ri_n, cd_n, cfg_ms_int_en} = 5'b1_1111;
    reg_addr = 4'h0; reg_wdata = 8'h00; rx_in_data = 8'h00;
    gpio_in = 8'hA5; cfg_mcr = 5'b0_0010; cfg_enh_en = 0;
    tx_hold_count = 7'h00; error_cnt = 0; total_checks = 0;
    reset = 1;
    repeat (10) @(posedge clk);
    #2 reset = 0;
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        wr(rows[i].a, rows[i].d);
      end else begin
        rd(rows[i].a, rows[i].d);
      end
    end
    wr(4'hC, 8'h01);
    gpio_in = 8'hA4;
    @(posedge clk); #2 chk(gpio_int, 1);
    rd(4'hB, 8'hA4);
    chk(gpio_int, 0);
    cts_n = 0;
    @(posedge clk); #2 chk(modem_int, 1);
    rd(4'h6, 8'h11);
    rd(4'h6, 8'h10);
    ri_n = 0;
    rd(4'h6, 8'h50);
    ri_n = 1;
    rd(4'h6, 8'h14);
    cfg_auto_cts = 1; cts_n = 1;
    #1 chk(tx_stop, 1);
    cts_n = 0;
    #1 chk(tx_stop, 0);
    tx_hold_count = 7'd3; tx_shift_busy = 1;
    rd(4'h5, 8'h00);
    rd(4'h8, 8'd61);
    tx_hold_count = 7'd0;
    rd(4'h5, 8'h20);
    tx_shift_busy = 0;
    push(8'h55, 3'b100);
    rd(4'h5, 8'hE5);
    chk(rx_out_data, 8'h55);
    push(8'h00, 3'b001);
    push(8'h00, 3'b001);
    rd(4'h9, 8'h02);
    // halt at 8 equals the code 0 triggers of 8, resume at 4 below them
    cfg_enh_en = 1; cfg_mcr = 5'b0_0110; cfg_auto_rts = 1;
    wr(4'h6, 8'h12);
    rd(4'h6, 8'h12);
    n = 0;
    while (rx_in_ready === 1'b1 && n < 70) begin
      push(n[7:0], 3'b000);
      n++;
    end
    chk(n[7:0], 8'd62);
    chk(rts_n, 1);
    rd(4'h9, 8'h40);
    push(8'hEE, 3'b000);
    rd(4'h5, 8'hE7);
    rd(4'h5, 8'hE5);
    rd_en = 1;
    n = 0;
    while (rx_out_valid !== 1'b0 && n < 300) begin
      @(posedge clk); #2 n++;
    end
    rd_en = 0;
    chk(rts_n, 0);
    rd(4'h9, 8'h00);
    rd(4'h5, 8'h60);
    chk(tx_ready_int, 1);
    chk(rx_data_int, 0);
    // pins last: modem select changes the modem status inputs
    wr(4'hA, 8'h22);
    wr(4'hB, 8'h00);
    chk(gpio_oe, 8'h22);
    chk(gpio_out, 8'h00);
    wr(4'hE, 8'h06);
    chk(gpio_out, 8'h22);
    chk(chb_modem_n, 8'h02);
    close_out();
  end
endmodule
`default_nettype wire
